// [include/vshpwm_if.sv]
`timescale 1ns/1ps
interface vshpwm_if;
  logic                          zc_rise;
  logic                          zc_fall;
  logic                          tmr_start;
  logic [vshpwm_pkg::TMR_W-1:0]  tmr_len;
  logic                          tmr_done;

  modport edge_mp  (output zc_rise, zc_fall);
  modport timer_mp (input tmr_start, tmr_len, output tmr_done);
  modport core_mp  (input zc_rise, zc_fall, tmr_done,
                    output tmr_start, tmr_len);
endinterface

// [include/vshpwm_pkg.sv]
package vshpwm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing, cycle counts derived from the 200 MHz controller clock; field widths
  localparam int CLK_MHZ       = 200;
  localparam int DEAD_MIN_NS   = 100;
  localparam int DEAD_MIN_CYC  = (DEAD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_MAX_NS   = 500;
  localparam int DEAD_MAX_CYC  = DEAD_MAX_NS * CLK_MHZ / 1000;
  localparam int HS_MAX_NS     = 10000;
  localparam int HS_MAX_CYC    = HS_MAX_NS * CLK_MHZ / 1000;
  localparam int NEG_MIN_NS    = 200;
  localparam int NEG_MIN_CYC   = (NEG_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W         = 16;
  localparam int CS_W          = 10;
  localparam int SKIP_W        = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SKIP   = 8'h04;
  localparam logic [7:0] OFS_PEAK   = 8'h08;
  localparam logic [7:0] OFS_LOWON  = 8'h0c;
  localparam logic [7:0] OFS_NEGON  = 8'h10;
  localparam logic [7:0] OFS_PDLY   = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_COUNT  = 8'h1c;

  // Control fields
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_VALLEY_BIT = 1;
  localparam int CTRL_AUTO_BIT   = 2;

  // Reset values
  localparam logic [2:0]        RST_CTRL  = 3'h0;
  localparam logic [SKIP_W-1:0] RST_SKIP  = 4'h2;
  localparam logic [CS_W-1:0]   RST_PEAK  = 10'h200;
  localparam logic [TMR_W-1:0]  RST_LOWON = 16'h0190;
  localparam logic [TMR_W-1:0]  RST_NEGON = 16'h0050;
  localparam logic [TMR_W-1:0]  RST_PDLY  = 16'h0028;

  // Light-load valley scaling: one extra valley per step below full demand
  localparam logic [CS_W-1:0]   AUTO_FULL  = 10'h3ff;
  localparam int                AUTO_SHIFT = 6;

  typedef enum logic [2:0] {
    ST_OFF, ST_GAP, ST_PDLY, ST_NEG, ST_DEAD_HS, ST_HS_ON, ST_DEAD_LS, ST_LS_ON
  } vshpwm_state_e;

endpackage

// [logic/vshpwm_core.sv]
// Contract
// - Valley mode inserts an idle gap after each full switching cycle.
// - Gap length set by configured number of valleys to skip.
// - Skipped valley count rises as load demand falls.
// - After the negative pulse run one high then low cycle, then gap.
// - Both switches off while waiting after demagnetization.
// - Waiting ends only on the selected zero-cross rising edge.
// - Fixed delay after the selected edge before low side turns on.
// - Low side on for negative pulse time, high side off.
// - After negative pulse, low side off, high side on once node high.
// - High side on-time ends when sensed current reaches peak set-point.
// - After high side off, low side on for programmed low-on time.
// - Under overcurrent, high side waits for a zero-cross edge.
// - Valley mode regulates via peak level and stretched period.
// - Zero-cross falling edge means node rising, rising means falling.
// - Continuous mode alternates switches with only dead-times between.
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module vshpwm_core
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          zero_cross_input_i,
  input  wire logic                          overcurrent_i,
  input  wire logic [vshpwm_pkg::CS_W-1:0]   current_sense_i,
  output logic                               high_side_switch_o,
  output logic                               low_side_switch_o
);
  import vshpwm_pkg::*;

  typedef struct packed {
    vshpwm_state_e     st;
    logic [2:0]        ctrl;
    logic [SKIP_W-1:0] skip;
    logic [CS_W-1:0]   peak;
    logic [TMR_W-1:0]  low_on_time;
    logic [TMR_W-1:0]  negative_pulse_time;
    logic [TMR_W-1:0]  pdly;
    logic [SKIP_W-1:0] vcnt;
    logic [7:0]        dcnt;
    logic              node_high;
    logic              zc_seen;
    logic              oc1;
    logic              oc2;
    logic [15:0]       cycles;
    logic              hs;
    logic              ls;
    logic              ack;
    logic [31:0]       dat;
  } vshpwm_core_s;

  vshpwm_core_s r;
  vshpwm_core_s next_r;

  vshpwm_if bus ();

  vshpwm_edge u_edge
  (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .zero_cross_input_i (zero_cross_input_i),
    .bus                (bus)
  );

  vshpwm_timer u_timer
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[i*8 +: 8] = dat[i*8 +: 8];
    return res;
  endfunction

  // Lower demand means more skipped valleys, saturating
  function automatic logic [SKIP_W-1:0] auto_skip(input logic [CS_W-1:0] p);
    logic [CS_W-1:0] steps;
    steps = (AUTO_FULL - p) >> AUTO_SHIFT;
    if (steps > CS_W'({SKIP_W{1'b1}}))
      return {SKIP_W{1'b1}};
    return steps[SKIP_W-1:0];
  endfunction

  // Short programmed pulses would undercut the far-side rectifier on-time
  function automatic logic [TMR_W-1:0] at_least(input logic [TMR_W-1:0] v,
                                                input int              m);
    if (v < TMR_W'(m))
      return TMR_W'(m);
    return v;
  endfunction

  logic              en;
  logic              valley;
  logic [SKIP_W-1:0] skip_eff;
  logic              wb_req;

  assign en       = r.ctrl[CTRL_EN_BIT];
  assign valley   = r.ctrl[CTRL_VALLEY_BIT];
  assign wb_req   = wb_cyc_i & wb_stb_i & ~r.ack;
  assign skip_eff = r.ctrl[CTRL_AUTO_BIT] ? auto_skip(r.peak)
                                          : r.skip;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [31:0] wr;
    wr            = '0;
    next_r        = r;
    bus.tmr_start = 1'b0;
    bus.tmr_len   = '0;
    next_r.oc1    = overcurrent_i;
    next_r.oc2    = r.oc1;
    next_r.dcnt   = r.dcnt + 8'h01;

    case (r.st)
      ST_OFF:
      begin
        if (en)
        begin
          next_r.st   = valley ? ST_GAP : ST_DEAD_HS;
          next_r.vcnt = '0;
          next_r.dcnt = '0;
          next_r.node_high = 1'b0;
        end
      end
      ST_GAP:
      begin
        if (bus.zc_rise)
        begin
          if (r.vcnt >= skip_eff)
          begin
            next_r.st     = ST_PDLY;
            bus.tmr_start = 1'b1;
            bus.tmr_len   = at_least(r.pdly, 1);
          end
          else
            next_r.vcnt = r.vcnt + 1'b1;
        end
      end
      ST_PDLY:
      begin
        if (bus.tmr_done)
        begin
          next_r.st     = ST_NEG;
          bus.tmr_start = 1'b1;
          bus.tmr_len   = at_least(r.negative_pulse_time, NEG_MIN_CYC);
        end
      end
      ST_NEG:
      begin
        if (bus.tmr_done)
        begin
          next_r.st        = ST_DEAD_HS;
          next_r.dcnt      = '0;
          next_r.node_high = 1'b0;
        end
      end
      ST_DEAD_HS:
      begin
        if (bus.zc_fall)
          next_r.node_high = 1'b1;
        // Node swing seen after minimum dead-time, or give up at maximum
        if ((r.dcnt >= 8'(DEAD_MIN_CYC - 1) && (r.node_high || bus.zc_fall))
            || r.dcnt >= 8'(DEAD_MAX_CYC - 1))
        begin
          next_r.st     = ST_HS_ON;
          next_r.cycles = r.cycles + 16'h0001;
          bus.tmr_start = 1'b1;
          bus.tmr_len   = TMR_W'(HS_MAX_CYC);
        end
      end
      ST_HS_ON:
      begin
        if (current_sense_i >= r.peak || bus.tmr_done)
        begin
          next_r.st   = ST_DEAD_LS;
          next_r.dcnt = '0;
        end
      end
      ST_DEAD_LS:
      begin
        if (r.dcnt >= 8'(DEAD_MIN_CYC - 1))
        begin
          next_r.st      = ST_LS_ON;
          next_r.zc_seen = 1'b0;
          bus.tmr_start  = 1'b1;
          bus.tmr_len    = at_least(r.low_on_time, 1);
        end
      end
      ST_LS_ON:
      begin
        if (bus.zc_rise || bus.zc_fall)
          next_r.zc_seen = 1'b1;
        if (bus.tmr_done &&
            (!r.oc2 || r.zc_seen || bus.zc_rise || bus.zc_fall))
        begin
          next_r.dcnt      = '0;
          next_r.node_high = 1'b0;
          next_r.vcnt      = '0;
          next_r.st        = valley ? ST_GAP : ST_DEAD_HS;
        end
      end
      default:
        next_r.st = ST_OFF;
    endcase

    if (!en)
      next_r.st = ST_OFF;

    next_r.hs = (next_r.st == ST_HS_ON);
    next_r.ls = (next_r.st == ST_NEG) || (next_r.st == ST_LS_ON);

    // Bus slave: ack one cycle after the request, unmapped reads zero
    next_r.ack = wb_req;
    next_r.dat = '0;
    if (wb_req && wb_we_i)
    begin
      if (wb_adr_i == OFS_CTRL)
      begin
        wr          = merge_lanes({29'h0, r.ctrl}, wb_dat_i, wb_sel_i);
        next_r.ctrl = wr[2:0];
      end
      else if (wb_adr_i == OFS_SKIP)
      begin
        wr          = merge_lanes({28'h0, r.skip}, wb_dat_i, wb_sel_i);
        next_r.skip = wr[SKIP_W-1:0];
      end
      else if (wb_adr_i == OFS_PEAK)
      begin
        wr          = merge_lanes({22'h0, r.peak}, wb_dat_i, wb_sel_i);
        next_r.peak = wr[CS_W-1:0];
      end
      else if (wb_adr_i == OFS_LOWON)
      begin
        wr = merge_lanes({16'h0, r.low_on_time}, wb_dat_i, wb_sel_i);
        next_r.low_on_time = wr[TMR_W-1:0];
      end
      else if (wb_adr_i == OFS_NEGON)
      begin
        wr = merge_lanes({16'h0, r.negative_pulse_time}, wb_dat_i, wb_sel_i);
        next_r.negative_pulse_time = wr[TMR_W-1:0];
      end
      else if (wb_adr_i == OFS_PDLY)
      begin
        wr          = merge_lanes({16'h0, r.pdly}, wb_dat_i, wb_sel_i);
        next_r.pdly = wr[TMR_W-1:0];
      end
    end
    else if (wb_req)
    begin
      if (wb_adr_i == OFS_CTRL)
        next_r.dat = {29'h0, r.ctrl};
      else if (wb_adr_i == OFS_SKIP)
        next_r.dat = {28'h0, r.skip};
      else if (wb_adr_i == OFS_PEAK)
        next_r.dat = {22'h0, r.peak};
      else if (wb_adr_i == OFS_LOWON)
        next_r.dat = {16'h0, r.low_on_time};
      else if (wb_adr_i == OFS_NEGON)
        next_r.dat = {16'h0, r.negative_pulse_time};
      else if (wb_adr_i == OFS_PDLY)
        next_r.dat = {16'h0, r.pdly};
      else if (wb_adr_i == OFS_STATUS)
        next_r.dat = {16'h0, skip_eff, r.vcnt, 1'b0, r.oc2,
                      r.ls, r.hs, 1'b0, r.st};
      else if (wb_adr_i == OFS_COUNT)
        next_r.dat = {16'h0, r.cycles};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r                     <= '0;
      r.st                  <= ST_OFF;
      r.ctrl                <= RST_CTRL;
      r.skip                <= RST_SKIP;
      r.peak                <= RST_PEAK;
      r.low_on_time         <= RST_LOWON;
      r.negative_pulse_time <= RST_NEGON;
      r.pdly                <= RST_PDLY;
    end
    else
      r <= next_r;
  end

  assign high_side_switch_o = r.hs;
  assign low_side_switch_o  = r.ls;
  assign wb_ack_o           = r.ack;
  assign wb_dat_o           = r.dat;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_switch_excl: assert property (
    !(high_side_switch_o && low_side_switch_o))
    else $error("both switches on");

  a_dead_ls_hs: assert property (
    $fell(low_side_switch_o) |-> !high_side_switch_o [*8])
    else $error("high side on within dead-time");

  a_dead_hs_ls: assert property (
    $fell(high_side_switch_o) |-> !low_side_switch_o [*8])
    else $error("low side on within dead-time");

  a_gap_both_off: assert property (
    r.st == ST_GAP |-> !high_side_switch_o && !low_side_switch_o)
    else $error("switch on during idle gap");

  a_gap_no_early: assert property (
    (r.st == ST_GAP && en && bus.zc_rise && r.vcnt < skip_eff)
    |=> r.st == ST_GAP)
    else $error("gap left before selected valley");

  a_pdly_holds_ls: assert property (
    (r.st == ST_PDLY && !bus.tmr_done) |=> !low_side_switch_o)
    else $error("low side on before delay");

  a_peak_ends_hs: assert property (
    (r.st == ST_HS_ON && current_sense_i >= r.peak) |=>
    !high_side_switch_o)
    else $error("high side not ended at peak");

  a_valley_one_cyc: assert property (
    (r.st == ST_LS_ON && en && valley) ##1 (r.st != ST_LS_ON)
    |-> r.st == ST_GAP)
    else $error("valley mode did not return to gap");

  a_oc_hold_ls: assert property (
    (r.st == ST_LS_ON && en && bus.tmr_done && r.oc2 && !r.zc_seen
     && !bus.zc_rise && !bus.zc_fall) |=> low_side_switch_o)
    else $error("high side not delayed under overcurrent");

  a_wb_ack_next: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one cycle after request");

endmodule // vshpwm_core

// [logic/vshpwm_edge.sv]
`timescale 1ns/1ps
module vshpwm_edge
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic zero_cross_input_i,
  vshpwm_if.edge_mp bus
);
  import vshpwm_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } vshpwm_edge_s;

  vshpwm_edge_s r;
  vshpwm_edge_s next_r;

  always_comb
  begin
    next_r    = r;
    next_r.s1 = zero_cross_input_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= next_r;
  end

  // Edge detect only on the second and third stages
  assign bus.zc_rise = r.s2 & ~r.s3;
  assign bus.zc_fall = ~r.s2 & r.s3;
endmodule // vshpwm_edge

// [logic/vshpwm_timer.sv]
`timescale 1ns/1ps
module vshpwm_timer
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  vshpwm_if.timer_mp bus
);
  import vshpwm_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } vshpwm_timer_s;

  vshpwm_timer_s r;
  vshpwm_timer_s next_r;

  always_comb
  begin
    next_r = r;
    if (bus.tmr_start)
      next_r.cnt = bus.tmr_len;
    else if (r.cnt != '0)
      next_r.cnt = r.cnt - 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= next_r;
  end

  // Level: expired and idle until the next start
  assign bus.tmr_done = (r.cnt == '0);
endmodule // vshpwm_timer

// [tb/vshpwm_bench.sv]
`timescale 1ns/1ps
module vshpwm_bench;
  import vshpwm_pkg::*;

  localparam int STEP  = 8;
  localparam int DEMAG = 200;

  typedef struct {
    logic [7:0]  adr;
    logic [31:0] wr;
    logic [31:0] exp;
  } vshpwm_row_s;

  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            cyc = 1'b0;
  logic            stb = 1'b0;
  logic            we = 1'b0;
  logic [7:0]      adr = 8'h00;
  logic [31:0]     dat_w = 32'h0;
  logic [31:0]     dat_r;
  logic            ack;
  logic            zc;
  logic            oc = 1'b0;
  logic            ring_en = 1'b1;
  logic [CS_W-1:0] cs;
  logic            hs;
  logic            ls;
  logic [2:0]      ctrl_v = 3'h0;
  logic [31:0]     q;
  logic            hs_p;
  logic            ls_p;
  logic            zc_p;
  int n_errors = 0;
  int tests_run = 0;
  int exp_skip, exp_peak, hs_rise_n, ls_rise_n, n, e;
  int lowon = 100, negon = 40, pdly = 8;
  int hs_len, ls_len, off_len, zc_cnt, zc_age, hs_since;
  bit seen, after_hs, is_neg, armed, rh, fh, rl, fl;

  vshpwm_row_s rows [9] = '{
    '{OFS_SKIP, 32'h0000_00f2, 32'h2},
    '{OFS_PEAK, 32'h0000_fd00, 32'h100},
    '{OFS_LOWON, 32'h0001_0064, 32'h64},
    '{OFS_NEGON, 32'h0000_0028, 32'h28},
    '{OFS_PDLY, 32'h0000_0008, 32'h8},
    '{OFS_CTRL, 32'h0000_00f8, 32'h0},
    '{OFS_COUNT, 32'h0000_0055, 32'h0},
    '{8'h20, 32'h0000_00ff, 32'h0},
    '{8'hfc, 32'h1234_5678, 32'h0}
  };
  logic [7:0]  r_adr [6] = '{OFS_CTRL, OFS_SKIP, OFS_PEAK,
                             OFS_LOWON, OFS_NEGON, OFS_PDLY};
  logic [31:0] r_exp [6] = '{32'(RST_CTRL), 32'(RST_SKIP),
                             32'(RST_PEAK), 32'(RST_LOWON),
                             32'(RST_NEGON), 32'(RST_PDLY)};

  always #2.5 clk = ~clk;

  vshpwm_core dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .zero_cross_input_i(zc), .overcurrent_i(oc), .current_sense_i(cs),
    .high_side_switch_o(hs), .low_side_switch_o(ls));

  vshpwm_stage #(.STEP(STEP), .DEMAG(DEMAG)) far (.clk_i(clk),
    .rst_i(rst), .ring_en_i(ring_en), .high_side_switch_i(hs),
    .low_side_switch_i(ls), .current_sense_o(cs), .zero_cross_o(zc));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok)
    begin
      n_errors++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 100);
    r = dat_r;
    chk(k < 100, "bus timeout");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask

  task automatic cfg(input logic [2:0] c, input int sk, input int pk);
    ctrl_v = 3'h0;
    wr(OFS_CTRL, 32'h0);
    // Auto mode must ignore the stored skip
    wr(OFS_SKIP, c[2] ? 32'h1 : 32'(sk));
    wr(OFS_PEAK, 32'(pk));
    exp_skip = sk;
    exp_peak = pk;
    ctrl_v = c;
    wr(OFS_CTRL, 32'(c));
  endtask

  task automatic wait_hs(input int k);
    int t;
    int c;
    t = hs_rise_n + k;
    c = 0;
    while (hs_rise_n < t && c < 20000)
    begin
      @(posedge clk);
      c++;
    end
    chk(c < 20000, "switching stalled");
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Gate monitor; pulse kind comes from what the previous pulse was
  always @(posedge clk)
  begin
    rh = hs === 1'b1 && hs_p === 1'b0;
    fh = hs === 1'b0 && hs_p === 1'b1;
    rl = ls === 1'b1 && ls_p === 1'b0;
    fl = ls === 1'b0 && ls_p === 1'b1;
    if (rst || ctrl_v[0] !== 1'b1)
    begin
      seen = 0;
      after_hs = 0;
      armed = 0;
      is_neg = 0;
      hs_since = 0;
      zc_cnt = 0;
      zc_age = 0;
      hs_len = 0;
      ls_len = 0;
      off_len = 0;
    end
    else
    begin
      chk(!(hs === 1'b1 && ls === 1'b1), "both switches on");
      if ((rh || rl) && seen)
      begin
        chk(off_len >= DEAD_MIN_CYC, "dead time short");
        if (!ctrl_v[1])
          chk(off_len <= DEAD_MAX_CYC + 5, "gap in continuous");
      end
      if (rl)
      begin
        ls_rise_n++;
        is_neg = ctrl_v[1] && !after_hs;
        if (is_neg && armed)
        begin
          chk(zc_cnt == exp_skip + 1, "wrong valley");
          chk(zc_age >= pdly && zc_age <= pdly + 8, "pulse delay");
          chk(hs_since == 1, "cycles per pulse");
        end
        if (is_neg)
          hs_since = 0;
        after_hs = 0;
      end
      if (rh)
        hs_rise_n++;
      if (fh)
      begin
        n = exp_peak / STEP;
        chk(hs_len >= n && hs_len <= n + 5, "high on-time");
        hs_since++;
        after_hs = 1;
      end
      if (fl && is_neg && !oc)
        chk(ls_len >= negon && ls_len <= negon + 4, "neg pulse");
      if (fl && !is_neg && oc)
        chk(ls_len >= DEMAG, "overcurrent hold");
      if (fl && !is_neg && !oc)
        chk(ls_len >= lowon && ls_len <= lowon + 4, "low on-time");
      if (fl && !is_neg && ctrl_v[1])
      begin
        armed = 1;
        zc_cnt = 0;
      end
      seen = seen || fh || fl;
      zc_age++;
      if (zc === 1'b1 && zc_p === 1'b0 && hs !== 1'b1 && ls !== 1'b1)
      begin
        zc_cnt++;
        zc_age = 0;
      end
      hs_len = (hs === 1'b1) ? hs_len + 1 : 0;
      ls_len = (ls === 1'b1) ? ls_len + 1 : 0;
      off_len = (hs === 1'b1 || ls === 1'b1) ? 0 : off_len + 1;
    end
    hs_p = hs;
    ls_p = ls;
    zc_p = zc;
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #300000;
    n_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    end_of_test;
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].adr, rows[i].wr);
      wb(1'b0, rows[i].adr, 32'h0, q);
      chk(q === rows[i].exp, "register readback");
    end
    $display("test registers done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(hs === 1'b0 && ls === 1'b0, "gates on in reset");
    foreach (r_adr[i])
    begin
      wb(1'b0, r_adr[i], 32'h0, q);
      chk(q === r_exp[i], "reset value");
    end
    wr(OFS_LOWON, 32'(lowon));
    wr(OFS_NEGON, 32'(negon));
    wr(OFS_PDLY, 32'(pdly));
    $display("test reset done");
    foreach (r_exp[i])
    begin
      if (i < 2)
      begin
        cfg(3'b011, i * 3, 'h100);
        wait_hs(4);
      end
    end
    $display("test valley done");
    foreach (r_exp[i])
    begin
      if (i < 3)
      begin
        n = (i == 0) ? 'h3ff : (i == 1) ? 'h1c0 : 0;
        e = (int'(AUTO_FULL) - n) >> AUTO_SHIFT;
        e = (e > 15) ? 15 : e;
        cfg(3'b111, e, n);
        wb(1'b0, OFS_STATUS, 32'h0, q);
        chk(q[15:12] === 4'(e), "auto skip");
        wait_hs(3);
      end
    end
    $display("test auto skip done");
    cfg(3'b011, 2, 'h100);
    wait_hs(2);
    ring_en <= 1'b0;
    n = ls_rise_n;
    e = hs_rise_n;
    repeat (1500) @(posedge clk);
    chk(ls_rise_n - n == 1 && hs_rise_n == e, "early end");
    ring_en <= 1'b1;
    wait_hs(2);
    oc <= 1'b1;
    wait_hs(3);
    oc <= 1'b0;
    wait_hs(2);
    $display("test valley hold done");
    cfg(3'b001, 2, 'h100);
    wait_hs(4);
    ctrl_v = 3'h0;
    wr(OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk(hs === 1'b0 && ls === 1'b0, "gates on after disable");
    wb(1'b0, OFS_COUNT, 32'h0, q);
    chk(q === 32'(hs_rise_n), "pulse count");
    $display("test continuous done");
    end_of_test;
  end
endmodule // vshpwm_bench

// [tb/vshpwm_stage.sv]
`timescale 1ns/1ps
module vshpwm_stage
#(
  parameter int STEP  = 8,
  parameter int HALF  = 60,
  parameter int SWING = 10,
  parameter int DEMAG = 200
)
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ring_en_i,
  input  wire logic                        high_side_switch_i,
  input  wire logic                        low_side_switch_i,
  output logic      [vshpwm_pkg::CS_W-1:0] current_sense_o,
  output logic                             zero_cross_o
);
  import vshpwm_pkg::*;

  int   hs_t;
  int   ls_t;
  int   off_t;
  int   rt;
  logic ring;
  logic last_hs;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hs_t    <= 0;
      ls_t    <= 0;
      off_t   <= 0;
      rt      <= 0;
      ring    <= 1'b0;
      last_hs <= 1'b0;
    end
    else
    begin
      hs_t  <= high_side_switch_i ? hs_t + 1 : 0;
      ls_t  <= low_side_switch_i ? ls_t + 1 : 0;
      off_t <= (high_side_switch_i || low_side_switch_i) ? 0 : off_t + 1;
      if (high_side_switch_i || low_side_switch_i)
        last_hs <= high_side_switch_i;
      // Free ringing after demag; stops when the bench holds it
      if (ring_en_i)
        rt <= (rt == HALF - 1) ? 0 : rt + 1;
      if (ring_en_i && rt == HALF - 1)
        ring <= ~ring;
    end
  end

  // Ramp saturates instead of wrapping at full scale
  assign current_sense_o = (hs_t * STEP > 1023) ? 10'h3ff
                                                : 10'(hs_t * STEP);

  // Node high gives a low comparator, node low a high one
  always_comb
  begin
    if (high_side_switch_i)
      zero_cross_o = 1'b0;
    else if (low_side_switch_i)
      zero_cross_o = (ls_t < DEMAG) ? 1'b1 : ring;
    // After high side off the low-side diode clamps the node low
    else if (off_t < SWING || (last_hs && off_t < DEMAG))
      zero_cross_o = last_hs;
    else
      zero_cross_o = ring;
  end
endmodule // vshpwm_stage
